//--- core/int_wdt_pkg.sv
package int_wdt_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int SYS_CLK_HZ      = 20_000_000;
	localparam int WDT_PERIOD_MS   = 18;
	localparam int WDT_CYCLES_DFLT = WDT_PERIOD_MS * (SYS_CLK_HZ / 1000);

	// ****************************************************************
	// Register map, index form; byte address is four times the index
	// ****************************************************************
	localparam int          AXI_AW           = 16;
	localparam logic [13:0] IDX_CORE_STATUS  = 14'h0003;
	localparam logic [13:0] IDX_INT_CONTROL  = 14'h000B;
	localparam logic [13:0] IDX_PERIPH_FLAGS = 14'h000C;
	localparam logic [13:0] IDX_OPTION       = 14'h0081;
	localparam logic [13:0] IDX_PERIPH_EN    = 14'h008C;
	localparam logic [13:0] IDX_FUSE         = 14'h2007;

	localparam logic [7:0] RST_INT_CONTROL  = 8'h00;
	localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
	localparam logic [7:0] RST_OPTION       = 8'hFF;
	localparam logic [7:0] RST_PERIPH_EN    = 8'h00;
	localparam logic [7:0] FUSE_DFLT        = 8'hFF;
	localparam logic [7:0] PERIPH_MASK      = 8'h40;

	localparam int FUSE_WDT_BIT  = 2;
	localparam int ST_EXPIRY_BIT = 4;
	localparam int ST_ASLEEP_BIT = 3;
	localparam int PF_CMP_BIT    = 6;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic global_int_enable;
		logic peripheral_int_enable;
		logic timer_overflow_enable;
		logic ext_int_enable;
		logic port_change_enable;
		logic timer_overflow_flag;
		logic ext_int_flag;
		logic port_change_flag;
	} int_control_t;

	typedef struct packed {
		logic       port_pullup_off;
		logic       edge_select;
		logic       timer_clk_source;
		logic       timer_source_edge;
		logic       prescaler_assign;
		logic [2:0] prescale_ratio;
	} option_t;

	typedef enum logic [2:0] {
		SEL_NONE    = 3'b000,
		SEL_INTCTL  = 3'b001,
		SEL_PFLAGS  = 3'b010,
		SEL_OPTION  = 3'b011,
		SEL_PEN     = 3'b100,
		SEL_FUSE    = 3'b101,
		SEL_STATUS  = 3'b110
	} reg_sel_t;

endpackage

//--- core/int_wdt_core.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
// How it works
// RULE_01: External pin is edge triggered; edge_select high means rising, low falling.
// RULE_02: A valid external edge sets ext_int_flag, interrupt_control bit 1.
// RULE_03: Clearing ext_int_enable, bit 4, stops the external pin interrupt.
// RULE_04: Software clears ext_int_flag before re-enabling; hardware never clears it.
// RULE_05: External edge wakes from sleep only if ext_int_enable was set beforehand.
// RULE_06: After wake-up, vector only when global_int_enable set, else continue.
// RULE_07: Timer rollover from maximum to zero sets timer_overflow_flag, bit 2.
// RULE_08: timer_overflow_enable, bit 5, enables or disables the timer interrupt.
// RULE_09: Any change on upper port pins 7..4 sets port_change_flag, bit 0.
// RULE_10: port_change_enable sits at bit 3 and gates the port-change interrupt.
// RULE_11: A pin change coinciding with a port read may be missed.
// RULE_12: Watchdog counts from its own free-running source, also during sleep.
// RULE_13: Watchdog time-out while running forces a full device reset.
// RULE_14: Watchdog time-out while asleep wakes the device instead of resetting.
// RULE_15: watchdog_fuse_enable clear disables the watchdog permanently.
// RULE_16: Without postscaler the watchdog times out after nominal 18 ms.
// RULE_17: Scaler assigned to watchdog extends time-out by ratio up to 1:128.
// RULE_18: Clear instruction or sleep clears watchdog and its assigned postscaler.
// RULE_19: Every watchdog time-out clears expiry_status_flag.
// RULE_20: One 8-bit scaler serves either the timer or the watchdog.
// RULE_21: prescaler_assign and prescale_ratio, option bits 3..0, select owner and ratio.
// RULE_22: Flags set on events regardless of enables; enables only gate requests.
// RULE_23: Interrupt request needs global enable plus a flagged, enabled source.
module int_wdt_core
	import int_wdt_pkg::*;
#(
	parameter int         WDT_CYCLES = WDT_CYCLES_DFLT,
	parameter logic [7:0] FUSE_WORD  = FUSE_DFLT
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              srst,
	// Pins
	input  wire logic              ext_int_pin,
	input  wire logic [3:0]        upper_port_pins,
	// Core and timer events
	input  wire logic              port_read,
	input  wire logic              timer_overflow,
	input  wire logic              timer_src_tick,
	input  wire logic              timer_write,
	input  wire logic              watchdog_clear_instr,
	input  wire logic              sleep_instr,
	// Core and timer results
	output logic                   timer_inc_q,
	output logic                   int_req_q,
	output logic                   wake_q,
	output logic                   wake_vector_q,
	output logic                   wdt_reset_q,
	output logic                   asleep_q,
	output logic                   expiry_status_flag_q,
	// AXI4-Lite slave
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	localparam int BW = $clog2(WDT_CYCLES + 1);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic reg_sel_t reg_sel(input logic [AXI_AW-1:0] addr);
		logic [13:0] idx;
		idx = addr[AXI_AW-1:2];
		if (idx == IDX_INT_CONTROL)
			return SEL_INTCTL;
		if (idx == IDX_PERIPH_FLAGS)
			return SEL_PFLAGS;
		if (idx == IDX_OPTION)
			return SEL_OPTION;
		if (idx == IDX_PERIPH_EN)
			return SEL_PEN;
		if (idx == IDX_FUSE)
			return SEL_FUSE;
		if (idx == IDX_CORE_STATUS)
			return SEL_STATUS;
		return SEL_NONE;
	endfunction

	function automatic logic [7:0] ratio_mask(input logic [2:0] ps, input logic extra);
		logic [8:0] m;
		m = (9'h001 << ({1'b0, ps} + {3'b000, extra})) - 9'h001;
		return m[7:0];
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	logic              ext_s1_q;
	logic              ext_s2_q;
	logic              ext_s3_q;
	logic [3:0]        port_s1_q;
	logic [3:0]        port_s2_q;
	logic [3:0]        port_s3_q;
	int_control_t      intctl_q;
	int_control_t      intctl_d;
	option_t           option_q;
	logic [7:0]        pflags_q;
	logic [7:0]        pen_q;
	logic              ext_en_slp_q;
	logic [BW-1:0]     base_cnt_q;
	logic [7:0]        scaler_q;
	logic [AXI_AW-1:0] awaddr_q;
	logic              aw_full_q;
	logic [7:0]        wdata_q;
	logic              wstrb0_q;
	logic              w_full_q;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ext_s1_q  <= 1'b0;
			ext_s2_q  <= 1'b0;
			ext_s3_q  <= 1'b0;
			port_s1_q <= 4'h0;
			port_s2_q <= 4'h0;
			port_s3_q <= 4'h0;
		end else begin
			ext_s1_q  <= ext_int_pin;
			ext_s2_q  <= ext_s1_q;
			ext_s3_q  <= ext_s2_q;
			port_s1_q <= upper_port_pins;
			port_s2_q <= port_s1_q;
			port_s3_q <= port_s2_q;
		end
	end

	// ****************************************************************
	// Source decode
	// ****************************************************************
	wire ext_rise = ext_s2_q & ~ext_s3_q;
	wire ext_fall = ~ext_s2_q & ext_s3_q;
	// RULE_01: edge polarity select.
	wire ext_edge = option_q.edge_select ? ext_rise : ext_fall;
	// RULE_11: read collision drops change.
	wire port_chg = (port_s2_q != port_s3_q) & ~port_read;

	// RULE_03: external enable gating.
	wire ext_req = intctl_q.ext_int_flag & intctl_q.ext_int_enable;
	// RULE_08: timer enable gating.
	wire tmr_req = intctl_q.timer_overflow_flag & intctl_q.timer_overflow_enable;
	// RULE_10: port enable bit three.
	wire port_req = intctl_q.port_change_flag & intctl_q.port_change_enable;
	wire per_req = intctl_q.peripheral_int_enable & pflags_q[PF_CMP_BIT] & pen_q[PF_CMP_BIT];
	wire any_req = ext_req | tmr_req | port_req | per_req;

	// RULE_05: enable sampled at sleep.
	wire ext_wake = intctl_q.ext_int_flag & ext_en_slp_q;
	wire src_wake = ext_wake | tmr_req | port_req | per_req;

	// ****************************************************************
	// Register write path
	// ****************************************************************
	reg_sel_t wr_sel;
	reg_sel_t rd_sel;
	assign wr_sel = reg_sel(awaddr_q);
	assign rd_sel = reg_sel(s_axi_araddr);
	wire wr_do   = aw_full_q & w_full_q & ~s_axi_bvalid;
	wire wr_en   = wr_do & wstrb0_q;
	wire wr_ictl = wr_en & (wr_sel == SEL_INTCTL);
	wire [7:0] ictl_sw = wr_ictl ? wdata_q : intctl_q;
	// RULE_02: external edge sets flag.
	// RULE_07: overflow sets timer flag.
	// RULE_09: port change sets flag.
	// RULE_22: set regardless of enables, and set wins over a software clear.
	assign intctl_d = int_control_t'(ictl_sw | {5'b00000, timer_overflow, ext_edge, port_chg});

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			intctl_q <= int_control_t'(RST_INT_CONTROL);
			option_q <= option_t'(RST_OPTION);
			pflags_q <= RST_PERIPH_FLAGS;
			pen_q    <= RST_PERIPH_EN;
		end else begin
			// RULE_04: only software clears flags.
			intctl_q <= intctl_d;
			// RULE_21: option fields written.
			if (wr_en && wr_sel == SEL_OPTION)
				option_q <= option_t'(wdata_q);
			if (wr_en && wr_sel == SEL_PFLAGS)
				pflags_q <= wdata_q & PERIPH_MASK;
			if (wr_en && wr_sel == SEL_PEN)
				pen_q <= wdata_q & PERIPH_MASK;
		end
	end

	// ****************************************************************
	// Watchdog and shared scaler
	// ****************************************************************
	// RULE_15: fuse disables permanently.
	wire wdt_enabled = FUSE_WORD[FUSE_WDT_BIT];
	// RULE_18: clear on instruction or sleep.
	wire wdt_clr = watchdog_clear_instr | sleep_instr;
	// RULE_16: nominal period count.
	wire base_tick = wdt_enabled & (base_cnt_q == BW'(WDT_CYCLES - 1));
	wire wd_owns_sc = option_q.prescaler_assign;
	// RULE_17: watchdog ratio one to 2^ps.
	wire [7:0] wdt_mask = ratio_mask(option_q.prescale_ratio, 1'b0);
	wire [7:0] tmr_mask = ratio_mask(option_q.prescale_ratio, 1'b1);
	wire [7:0] sc_mask = wd_owns_sc ? wdt_mask : tmr_mask;
	wire sc_full = (scaler_q & sc_mask) == sc_mask;
	// RULE_20: scaler steps for its single owner.
	wire sc_step = wd_owns_sc ? base_tick : timer_src_tick;
	wire sc_clr = wd_owns_sc ? wdt_clr : timer_write;
	// A clear in the same cycle as expiry suppresses it, so software racing the
	// counter never loses to it.
	wire wdt_timeout = (wd_owns_sc ? (base_tick & sc_full) : base_tick) & ~wdt_clr;
	wire wake_now = asleep_q & (src_wake | wdt_timeout);

	always_ff @(posedge sys_clk) begin
		// RULE_12: free-running regardless of sleep.
		if (srst || wdt_clr || !wdt_enabled || base_tick)
			base_cnt_q <= '0;
		else
			base_cnt_q <= base_cnt_q + BW'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (srst || sc_clr || (sc_step && sc_full))
			scaler_q <= 8'h00;
		else if (sc_step)
			scaler_q <= scaler_q + 8'h01;
	end

	// ****************************************************************
	// Sleep, wake and outputs
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			asleep_q             <= 1'b0;
			ext_en_slp_q         <= 1'b0;
			wake_q               <= 1'b0;
			wake_vector_q        <= 1'b0;
			wdt_reset_q          <= 1'b0;
			int_req_q            <= 1'b0;
			timer_inc_q          <= 1'b0;
			expiry_status_flag_q <= 1'b1;
		end else begin
			if (wake_now)
				asleep_q <= 1'b0;
			else if (sleep_instr)
				asleep_q <= 1'b1;
			if (sleep_instr)
				ext_en_slp_q <= intctl_q.ext_int_enable;
			// RULE_14: wake instead of reset.
			wake_q <= wake_now;
			// RULE_06: vector needs global enable.
			wake_vector_q <= asleep_q & src_wake & intctl_q.global_int_enable;
			// RULE_13: reset when running.
			wdt_reset_q <= wdt_timeout & ~asleep_q;
			// RULE_23: global and source gating.
			int_req_q <= intctl_q.global_int_enable & any_req;
			timer_inc_q <= timer_src_tick & (wd_owns_sc | sc_full);
			// RULE_19: time-out clears expiry flag.
			if (wdt_timeout)
				expiry_status_flag_q <= 1'b0;
			else if (wdt_clr)
				expiry_status_flag_q <= 1'b1;
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	wire [7:0] status_rd = (8'(expiry_status_flag_q) << ST_EXPIRY_BIT)
		| (8'(asleep_q) << ST_ASLEEP_BIT);
	wire [7:0] rd_mux = (rd_sel == SEL_INTCTL) ? intctl_q :
		(rd_sel == SEL_PFLAGS) ? pflags_q :
		(rd_sel == SEL_OPTION) ? option_q :
		(rd_sel == SEL_PEN) ? pen_q :
		(rd_sel == SEL_FUSE) ? FUSE_WORD :
		(rd_sel == SEL_STATUS) ? status_rd : 8'h00;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= 8'h00;
			wstrb0_q      <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata[7:0];
				wstrb0_q     <= s_axi_wstrb[0];
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_mux};
			s_axi_rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_rise_sets;
		option_q.edge_select && ext_rise |=> intctl_q.ext_int_flag;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost"); // RULE_01

	property p_fall_ignored;
		option_q.edge_select && ext_fall && !intctl_q.ext_int_flag && !wr_ictl
			&& !$past(ext_edge) |=> !intctl_q.ext_int_flag;
	endproperty
	a_fall_ignored: assert property (p_fall_ignored) else $error("wrong edge set flag"); // RULE_01

	property p_flag_held;
		intctl_q.ext_int_flag && !wr_ictl |=> intctl_q.ext_int_flag;
	endproperty
	a_flag_held: assert property (p_flag_held) else $error("flag cleared by hw"); // RULE_04

	property p_timer_flag;
		timer_overflow |=> intctl_q.timer_overflow_flag;
	endproperty
	a_timer_flag: assert property (p_timer_flag) else $error("overflow flag lost"); // RULE_07

	property p_port_flag;
		(port_s2_q != port_s3_q) && !port_read |=> intctl_q.port_change_flag;
	endproperty
	a_port_flag: assert property (p_port_flag) else $error("port change lost"); // RULE_09

	property p_irq_cause;
		int_req_q |-> $past(intctl_q.global_int_enable) && $past(any_req);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("spurious request"); // RULE_23

	property p_wdt_reset;
		wdt_timeout && !asleep_q |=> wdt_reset_q && !wake_q;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("no watchdog reset"); // RULE_13

	property p_wdt_wake;
		wdt_timeout && asleep_q |=> wake_q && !wdt_reset_q && !asleep_q;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("no watchdog wake"); // RULE_14

	property p_fuse_off;
		!wdt_enabled |-> !wdt_timeout && base_cnt_q == '0;
	endproperty
	a_fuse_off: assert property (p_fuse_off) else $error("disabled watchdog ran"); // RULE_15

	property p_clr;
		wdt_clr |=> base_cnt_q == '0 && !wdt_reset_q;
	endproperty
	a_clr: assert property (p_clr) else $error("clear ignored"); // RULE_18

	property p_expiry;
		wdt_timeout |=> !expiry_status_flag_q;
	endproperty
	a_expiry: assert property (p_expiry) else $error("expiry flag not cleared"); // RULE_19

	property p_vector;
		wake_vector_q |-> wake_q && $past(intctl_q.global_int_enable);
	endproperty
	a_vector: assert property (p_vector) else $error("vector without enable"); // RULE_06

	c_wake: cover property (asleep_q ##1 wake_q && wake_vector_q);
	c_wdt_reset: cover property (wdt_reset_q);
	c_irq: cover property (!int_req_q ##1 int_req_q);
	c_bus_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);

endmodule // int_wdt_core

//--- verif/pin_partner.sv
`timescale 1ns/100ps
// ****************************************************************
// External pins and timer seen from the device
// ****************************************************************
module pin_partner (
	// Clock
	input  wire logic       sys_clk,
	// Pins and timer events
	output logic            ext_int_pin,
	output logic [3:0]      upper_port_pins,
	output logic            timer_overflow
);
	initial begin
		ext_int_pin = 1'h0;
		upper_port_pins = 4'h0;
		timer_overflow = 1'h0;
	end

	// Levels move just after an edge and then hold, so no sample lands on a change.
	task automatic set_ext(input logic lvl);
		ext_int_pin <= lvl;
	endtask

	task automatic set_port(input logic [3:0] v);
		upper_port_pins <= v;
	endtask

	// A rollover lasts exactly one clock, like the real counter wrap.
	task automatic pulse_ovf();
		timer_overflow <= 1'h1;
		@(posedge sys_clk);
		timer_overflow <= 1'h0;
	endtask
endmodule // pin_partner

//--- verif/tb_int_sources_and_watchdog.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_int_sources_and_watchdog
	import int_wdt_pkg::*;
;
	// A short watchdog base count keeps the run brief; every gap is derived from it.
	localparam int WC = 20;
	logic sys_clk = 1'h0;
	logic srst = 1'h1;
	logic port_read = 1'h0, timer_src_tick = 1'h0, timer_write = 1'h0;
	logic clr_instr = 1'h0, sleep_instr = 1'h0;
	logic ext_pin, tovf;
	logic [3:0] port_pins, pv = 4'h0;
	logic [15:0] awaddr = 16'h0, araddr = 16'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, v, tinc;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata;
	logic [7:0] rd;
	logic int_req_q, wake_q, wake_vector_q, wdt_reset_q, asleep_q, expiry_status_flag_q;
	int n_errors = 0, checked = 0, exp_ic = 0, n, k0, m, n_to = 0, n_inc = 0;

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (wdt_reset_q === 1'h1) n_to++;
	always @(posedge sys_clk) if (tinc === 1'h1) n_inc++;

	pin_partner p (.sys_clk(sys_clk), .ext_int_pin(ext_pin), .upper_port_pins(port_pins),
		.timer_overflow(tovf));

	int_wdt_core #(.WDT_CYCLES(WC)) uut (.sys_clk(sys_clk), .srst(srst),
		.ext_int_pin(ext_pin), .upper_port_pins(port_pins), .port_read(port_read),
		.timer_overflow(tovf), .timer_src_tick(timer_src_tick), .timer_write(timer_write),
		.watchdog_clear_instr(clr_instr), .sleep_instr(sleep_instr), .timer_inc_q(tinc),
		.int_req_q(int_req_q), .wake_q(wake_q), .wake_vector_q(wake_vector_q),
		.wdt_reset_q(wdt_reset_q), .asleep_q(asleep_q),
		.expiry_status_flag_q(expiry_status_flag_q),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// ****************************************************************
	// Bus and event tasks
	// ****************************************************************
	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		logic ga, gw;
		ga = 1'h0;
		gw = 1'h0;
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ga && gw)) begin
			@(posedge sys_clk);
			if (!ga && awready) begin
				ga = 1'h1;
				awvalid <= 1'h0;
			end
			if (!gw && wready) begin
				gw = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge sys_clk); while (!bvalid);
		rsp = bresp;
		bready <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic rdr(input logic [13:0] idx);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge sys_clk); while (!rvalid);
		rready <= 1'h0;
		rd = rdata[7:0];
		rsp = rresp;
		@(posedge sys_clk);
	endtask

	task automatic chk_ic();
		rdr(IDX_INT_CONTROL);
		`CHK(rd, exp_ic[7:0])
	endtask

	task automatic step_ext(input logic lvl, input logic hit);
		p.set_ext(lvl);
		tick(5);
		if (hit) exp_ic = exp_ic | 2;
		chk_ic();
		wr(IDX_INT_CONTROL, 8'h00);
		exp_ic = 0;
	endtask

	task automatic clr_pulse();
		clr_instr <= 1'h1;
		@(posedge sys_clk);
		clr_instr <= 1'h0;
	endtask

	task automatic gap(output int c);
		c = 0;
		do begin
			@(posedge sys_clk);
			c++;
		end while (!wdt_reset_q && c < 6000);
	endtask

	task automatic nap(input logic lvl, output int c);
		sleep_instr <= 1'h1;
		@(posedge sys_clk);
		sleep_instr <= 1'h0;
		p.set_ext(lvl);
		@(posedge sys_clk);
		`CHK(asleep_q, 1'h1)
		c = 1;
		do begin
			@(posedge sys_clk);
			c++;
		end while (!wake_q && c < 100);
		v = wake_vector_q;
	endtask

	task automatic stop_test();
		$display("errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge sys_clk);
		n_errors++;
		stop_test();
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		void'($urandom(14));
		tick(2);
		srst <= 1'h0;
		chk_ic();
		rdr(IDX_CORE_STATUS);
		`CHK(rd, 8'h01 << ST_EXPIRY_BIT)
		rdr(IDX_FUSE);
		`CHK(rd, FUSE_DFLT)
		rdr(IDX_OPTION);
		`CHK(rd, 8'hFF)
		`CHK(rsp, RESP_OKAY)
		rdr(14'h0005);
		`CHK(rsp, RESP_SLVERR)
		wr(14'h0005, 8'h00);
		`CHK(rsp, RESP_SLVERR)
		wr(IDX_OPTION, 8'h00);
		`CHK(rsp, RESP_OKAY)
		step_ext(1'h1, 1'h0);
		step_ext(1'h0, 1'h1);
		wr(IDX_OPTION, 8'h40);
		step_ext(1'h1, 1'h1);
		step_ext(1'h0, 1'h0);
		for (int i = 0; i < 4; i++) begin
			m = $urandom_range(15, 1);
			pv = pv ^ m[3:0];
			p.set_port(pv);
			tick(5);
			exp_ic = 1;
			chk_ic();
			wr(IDX_INT_CONTROL, 8'h00);
		end
		exp_ic = 0;
		port_read <= 1'h1;
		pv = ~pv;
		p.set_port(pv);
		tick(5);
		port_read <= 1'h0;
		chk_ic();
		p.pulse_ovf();
		p.set_ext(1'h1);
		p.set_port(~pv);
		tick(5);
		exp_ic = 7;
		chk_ic();
		`CHK(int_req_q, 1'h0)
		for (int i = 0; i < 3; i++) begin
			wr(IDX_INT_CONTROL, 8'h80 | (8'h08 << i) | (8'h01 << i));
			tick(2);
			`CHK(int_req_q, 1'h1)
			wr(IDX_INT_CONTROL, (8'h08 << i) | (8'h01 << i));
			tick(2);
			`CHK(int_req_q, 1'h0)
			wr(IDX_INT_CONTROL, 8'h80 | (8'h08 << i) | (8'h01 << ((i + 1) % 3)));
			tick(2);
			`CHK(int_req_q, 1'h0)
		end
		wr(IDX_PERIPH_FLAGS, 8'h40);
		wr(IDX_PERIPH_EN, 8'h40);
		wr(IDX_INT_CONTROL, 8'hC0);
		tick(2);
		`CHK(int_req_q, 1'h1)
		wr(IDX_PERIPH_FLAGS, 8'h00);
		wr(IDX_INT_CONTROL, 8'h00);
		gap(n);
		gap(n);
		`CHK(n, WC)
		`CHK(expiry_status_flag_q, 1'h0)
		clr_pulse();
		@(posedge sys_clk);
		`CHK(expiry_status_flag_q, 1'h1)
		k0 = n_to;
		for (int i = 0; i < 10; i++) begin
			clr_pulse();
			tick(WC / 2);
		end
		`CHK(n_to, k0)
		for (int r = 0; r < 8; r++) begin
			wr(IDX_OPTION, {5'h09, r[2:0]});
			clr_pulse();
			gap(n);
			gap(n);
			`CHK(n, WC << r)
		end
		for (int r = 0; r < 3; r++) begin
			wr(IDX_OPTION, {5'h00, r[2:0]});
			timer_write <= 1'h1;
			@(posedge sys_clk);
			timer_write <= 1'h0;
			timer_src_tick <= 1'h1;
			k0 = n_inc;
			tick(8 << r);
			timer_src_tick <= 1'h0;
			tick(2);
			`CHK(n_inc - k0, 4)
		end
		wr(IDX_OPTION, 8'h00);
		for (int g = 0; g < 2; g++) begin
			wr(IDX_INT_CONTROL, {g[0], 7'h10});
			nap(1'h0, n);
			`CHK(n < 8, 1'h1)
			`CHK(v, g[0])
			p.set_ext(1'h1);
			tick(5);
			wr(IDX_INT_CONTROL, 8'h00);
		end
		wr(IDX_INT_CONTROL, 8'h80);
		clr_pulse();
		tick(2);
		k0 = n_to;
		nap(1'h0, n);
		`CHK(n, WC + 1)
		`CHK(v, 1'h0)
		`CHK(n_to, k0)
		stop_test();
	end
endmodule // tb_int_sources_and_watchdog
